// file: core/tstq_top.sv
// Purpose: Two-step departure stamp queue with identifier pool and delay fix-up.
// Assumes: AXI4-Lite slave, one write and one read under way at a time.
// Notes:   Queue storage is flip-flops; all state is one registered struct.
//
// Summary of operation
// - Rewrite code 3 requests two-step stamping on any frame, frame left unmodified.
// - One shared stamp queue of 128 entries serves all egress ports.
// - Each entry shows one valid flag when ready for software.
// - A 6-bit identifier is given per stamped frame and stored in its entries.
// - Extracted frames carry the identifier in the header's DSCP position.
// - With identifiers 4-62 all taken, the frame gets 63, meaning untrustworthy.
// - Multi-port frames make one entry per port, same identifier, own port.
// - Entries made by two-step stamping have the maintenance origin flag clear.
// - A stamp arriving at a full queue is dropped and overflow is flagged.
// - The oldest entry is shown in the status and stamp value registers.
// - Any write to the advance register pops the oldest entry; nothing stored.
// - Two-step frames to CPU queues make no entry; header carries arrival stamp.
// - Identifiers 0-3 are kept for CPU injection; analyzer gives out the rest.
// - Writing ones to the release registers frees identifiers 32-63 and 0-31.
// - A per-port disable suppresses two-step stamping, overriding the classifier.
// - In 1G mode receive delay grows by 0.8 ns per barrel shifter step.
// - In 2.5G mode the barrel shifter step is worth 0.32 ns.
// - In 100FX mode receive delay shrinks by 0.8 ns per edge position step.
// - Code 2 adds residence time to correction; code 5 writes time of day.
`include "tstq_consts.svh"

module tstq_top #(
   parameter int DEPTH     = 128,
   parameter int NUM_PORTS = 16,
   parameter int DV_W      = 6
) (
   // Clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // AXI4-Lite write address and data
   input  wire logic [`TSTQ_AXI_AW-1:0]      s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // AXI4-Lite read
   input  wire logic [`TSTQ_AXI_AW-1:0]      s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // Classifier request and answer
   input  wire tstq_pkg::tstq_cls_req_t      cls_req,
   output tstq_pkg::tstq_cls_rsp_t           cls_rsp,
   // Egress departure stamps
   input  wire tstq_pkg::tstq_egr_stamp_t    egr_stamp,
   // Receive delay correction
   input  wire tstq_pkg::tstq_link_mode_t    link_mode,
   input  wire logic [DV_W-1:0]              barrel_delay,
   input  wire logic [DV_W-1:0]              fx_edge_position,
   input  wire logic [15:0]                  base_rx_delay_ps,
   output logic [15:0]                       rx_delay_ps
);
   import tstq_pkg::*;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [31:0] PORT_MASK =
      (NUM_PORTS >= 32) ? 32'hffff_ffff : 32'((33'h1 << NUM_PORTS) - 33'h1);

   typedef struct packed {
      tstq_entry_t [DEPTH-1:0] mem;
      logic [AW:0]             count;
      logic [AW-1:0]           rd_ptr;
      logic [AW-1:0]           wr_ptr;
      logic                    overflow;
      logic [63:0]             id_in_use;
      logic [31:0]             port_dis;
      logic                    aw_held;
      logic [7:0]              aw_addr;
      logic                    w_held;
      logic [31:0]             w_data;
      logic [3:0]              w_strb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      tstq_cls_rsp_t           cls_rsp;
      logic [15:0]             rx_delay_ps;
   } tstq_state_t;

   tstq_state_t st;
   tstq_state_t next_st;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [AW-1:0] tstq_ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   function automatic logic [7:0] tstq_word(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   function automatic logic [31:0] tstq_lanes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // Lowest free analyzer identifier; 0-3 are never handed out here.
   function automatic logic [5:0] tstq_first_free(input logic [63:0] used);
      logic [5:0] id;
      id = `TSTQ_ID_NONE;
      for (int i = 62; i >= 4; i--) begin
         if (!used[i]) begin
            id = 6'(i);
         end
      end
      return id;
   endfunction

   logic        do_wr;
   logic [7:0]  wr_addr;
   logic [31:0] wr_mask;
   logic        pop_req;
   logic        egr_two_step;
   logic        dis_hit;
   logic        egr_take;
   logic        egr_drop;
   logic        queue_empty;
   tstq_entry_t head;
   logic [5:0]  free_id;
   logic        need_id;
   logic [31:0] dly_add;
   logic [31:0] dly_sub;
   logic [31:0] dly_sum;

   assign do_wr        = st.aw_held && st.w_held && !st.bvalid;
   assign wr_addr      = tstq_word(st.aw_addr);
   assign wr_mask      = st.w_data & tstq_lanes(st.w_strb);
   assign queue_empty  = (st.count == '0);
   assign head         = st.mem[st.rd_ptr];
   assign pop_req      = do_wr && (wr_addr == `TSTQ_OFS_ADVANCE) && !queue_empty;
   assign dis_hit      = (egr_stamp.entry_tx_port < 8'h20) &&
                         st.port_dis[egr_stamp.entry_tx_port[4:0]];
   assign egr_two_step = egr_stamp.valid &&
                         (egr_stamp.rewrite_operation == `TSTQ_OP_TWO_STEP) &&
                         !egr_stamp.to_cpu &&
                         !dis_hit;
   assign egr_take     = egr_two_step && (st.count != FULL_CNT);
   assign egr_drop     = egr_two_step && (st.count == FULL_CNT);
   assign free_id      = tstq_first_free(st.id_in_use);
   assign need_id      = cls_req.valid && cls_req.to_ports &&
                         (cls_req.rewrite_operation == `TSTQ_OP_TWO_STEP);

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_st = st;
      dly_add = '0;
      dly_sub = '0;
      dly_sum = 32'(base_rx_delay_ps);
      next_st.cls_rsp = '0;

      // Register bus: hold address and data until both are present.
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (do_wr) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = `TSTQ_RESP_OKAY;
         case (wr_addr)
            `TSTQ_OFS_TX_STAMP: begin
            end
            `TSTQ_OFS_ADVANCE: begin
            end
            `TSTQ_OFS_STATUS: begin
               if (wr_mask[`TSTQ_ST_OVFL]) begin
                  next_st.overflow = 1'b0;
               end
            end
            `TSTQ_OFS_REL_UPPER: begin
               next_st.id_in_use[63:32] = st.id_in_use[63:32] & ~wr_mask;
            end
            `TSTQ_OFS_REL_LOWER: begin
               next_st.id_in_use[31:0] = st.id_in_use[31:0] & ~wr_mask;
            end
            `TSTQ_OFS_PORT_DIS: begin
               next_st.port_dis = ((st.port_dis & ~tstq_lanes(st.w_strb)) | wr_mask) &
                                  PORT_MASK;
            end
            default: begin
               next_st.bresp = `TSTQ_RESP_SLVERR;
            end
         endcase
      end
      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready  = !next_st.w_held && !next_st.bvalid;

      // Register bus: reads answer one cycle after the address is taken.
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = '0;
         next_st.rresp  = `TSTQ_RESP_OKAY;
         case (tstq_word(s_axi_araddr))
            `TSTQ_OFS_TX_STAMP: begin
               if (!queue_empty) begin
                  next_st.rdata = head.stamp;
               end
            end
            `TSTQ_OFS_STATUS: begin
               // An empty queue shows every entry field as zero.
               if (!queue_empty) begin
                  next_st.rdata[`TSTQ_ST_VLD]     = 1'b1;
                  next_st.rdata[`TSTQ_ST_ID +: 6] = head.stamp_identifier;
                  next_st.rdata[`TSTQ_ST_PORT +: 8] = head.entry_tx_port;
                  next_st.rdata[`TSTQ_ST_OAM]     = head.maintenance_origin_flag;
               end
               next_st.rdata[`TSTQ_ST_OVFL] = st.overflow;
            end
            `TSTQ_OFS_ADVANCE, `TSTQ_OFS_REL_UPPER, `TSTQ_OFS_REL_LOWER: begin
            end
            `TSTQ_OFS_PORT_DIS: begin
               next_st.rdata = st.port_dis;
            end
            default: begin
               next_st.rresp = `TSTQ_RESP_SLVERR;
            end
         endcase
      end
      next_st.arready = !next_st.rvalid;

      // Stamp queue. A full queue refuses even when a pop lands in the same cycle.
      if (pop_req) begin
         next_st.rd_ptr = tstq_ptr_inc(st.rd_ptr);
      end
      if (egr_take) begin
         next_st.mem[st.wr_ptr].stamp_identifier = egr_stamp.stamp_identifier;
         next_st.mem[st.wr_ptr].entry_tx_port    = egr_stamp.entry_tx_port;
         next_st.mem[st.wr_ptr].maintenance_origin_flag = 1'b0;
         next_st.mem[st.wr_ptr].stamp            = egr_stamp.stamp;
         next_st.wr_ptr = tstq_ptr_inc(st.wr_ptr);
      end
      next_st.count = st.count + (AW+1)'(egr_take) - (AW+1)'(pop_req);
      if (egr_drop) begin
         next_st.overflow = 1'b1;
      end

      // Identifier pool. Allocation follows release, so a set beats a clear.
      if (cls_req.valid) begin
         next_st.cls_rsp.valid = 1'b1;
         next_st.cls_rsp.two_step = (cls_req.rewrite_operation == `TSTQ_OP_TWO_STEP);
         next_st.cls_rsp.one_step_correction =
            (cls_req.rewrite_operation == `TSTQ_OP_ONE_STEP);
         next_st.cls_rsp.origin_write = (cls_req.rewrite_operation == `TSTQ_OP_ORIGIN);
         next_st.cls_rsp.frame_modify = next_st.cls_rsp.one_step_correction ||
                                        next_st.cls_rsp.origin_write;
         next_st.cls_rsp.hdr_dscp = cls_req.dscp;
         if (need_id) begin
            next_st.cls_rsp.stamp_identifier = free_id;
            if (free_id != `TSTQ_ID_NONE) begin
               next_st.id_in_use[free_id] = 1'b1;
            end
            if (cls_req.to_cpu) begin
               next_st.cls_rsp.hdr_dscp = free_id;
            end
         end
         if (next_st.cls_rsp.two_step && cls_req.to_cpu) begin
            next_st.cls_rsp.hdr_arrival_valid = 1'b1;
            next_st.cls_rsp.hdr_arrival_stamp = cls_req.arrival_stamp;
         end
      end

      // Receive delay, saturated to the 16-bit output range.
      case (link_mode)
         tstq_mode_1g: begin
            dly_add = `TSTQ_RX_ADJ_1G_PS * 32'(barrel_delay);
         end
         tstq_mode_2g5: begin
            dly_add = `TSTQ_RX_ADJ_2G5_PS * 32'(barrel_delay);
         end
         tstq_mode_100fx: begin
            dly_sub = `TSTQ_RX_ADJ_FX_PS * 32'(fx_edge_position);
         end
         default: begin
         end
      endcase
      dly_sum = 32'(base_rx_delay_ps) + dly_add;
      if (dly_sub > dly_sum) begin
         next_st.rx_delay_ps = '0;
      end else if ((dly_sum - dly_sub) > 32'h0000_ffff) begin
         next_st.rx_delay_ps = 16'hffff;
      end else begin
         next_st.rx_delay_ps = 16'(dly_sum - dly_sub);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st          <= '0;
         st.port_dis <= `TSTQ_PORT_DIS_RST;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_arready = st.arready;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign s_axi_rvalid  = st.rvalid;
   assign cls_rsp       = st.cls_rsp;
   assign rx_delay_ps   = st.rx_delay_ps;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_take_alone;
      egr_take && !pop_req;
   endsequence

   sequence s_status_read;
      s_axi_arvalid && st.arready && (tstq_word(s_axi_araddr) == `TSTQ_OFS_STATUS);
   endsequence

   property p_push_count;
      s_take_alone |=> st.count == $past(st.count) + 1'b1;
   endproperty
   a_push_count: assert property (p_push_count) else $error("push not counted");

   property p_entry_id;
      s_take_alone |=> st.mem[$past(st.wr_ptr)].stamp_identifier ==
                       $past(egr_stamp.stamp_identifier);
   endproperty
   a_entry_id: assert property (p_entry_id) else $error("entry id wrong");

   property p_entry_port;
      egr_take |=> st.mem[$past(st.wr_ptr)].entry_tx_port == $past(egr_stamp.entry_tx_port);
   endproperty
   a_entry_port: assert property (p_entry_port) else $error("entry port wrong");

   property p_oam_clear;
      egr_take |=> !st.mem[$past(st.wr_ptr)].maintenance_origin_flag;
   endproperty
   a_oam_clear: assert property (p_oam_clear) else $error("origin flag set");

   property p_overflow;
      egr_drop && !pop_req |=> st.overflow && (st.count == FULL_CNT);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow missed");

   property p_disabled_port;
      egr_stamp.valid && dis_hit && !pop_req |=> st.count == $past(st.count);
   endproperty
   a_disabled_port: assert property (p_disabled_port) else $error("disabled port queued");

   property p_cpu_no_entry;
      egr_stamp.valid && egr_stamp.to_cpu && !pop_req |=> st.count == $past(st.count);
   endproperty
   a_cpu_no_entry: assert property (p_cpu_no_entry) else $error("cpu frame queued");

   property p_pop;
      pop_req && !egr_take |=> st.count == $past(st.count) - 1'b1 && st.rd_ptr != $past(st.rd_ptr);
   endproperty
   a_pop: assert property (p_pop) else $error("advance did not pop");

   property p_empty_advance;
      do_wr && (wr_addr == `TSTQ_OFS_ADVANCE) && queue_empty && !egr_take
         |=> queue_empty && (st.rd_ptr == $past(st.rd_ptr));
   endproperty
   a_empty_advance: assert property (p_empty_advance) else $error("empty advance moved");

   property p_status_valid;
      s_status_read |=> st.rvalid && (st.rdata[`TSTQ_ST_VLD] == ($past(st.count) != '0));
   endproperty
   a_status_valid: assert property (p_status_valid) else $error("status valid wrong");

   property p_id_range;
      need_id |=> (st.cls_rsp.stamp_identifier >= `TSTQ_ID_FIRST_ANA);
   endproperty
   a_id_range: assert property (p_id_range) else $error("reserved id given");

   property p_id_none;
      need_id && (&st.id_in_use[62:4]) |=> st.cls_rsp.stamp_identifier == `TSTQ_ID_NONE;
   endproperty
   a_id_none: assert property (p_id_none) else $error("exhausted pool not 63");

   property p_release_low;
      do_wr && (wr_addr == `TSTQ_OFS_REL_LOWER) && !need_id
         |=> (st.id_in_use[31:0] & $past(wr_mask)) == '0;
   endproperty
   a_release_low: assert property (p_release_low) else $error("release ignored");

   property p_two_step_plain;
      cls_req.valid && (cls_req.rewrite_operation == `TSTQ_OP_TWO_STEP)
         |=> st.cls_rsp.valid && st.cls_rsp.two_step && !st.cls_rsp.frame_modify;
   endproperty
   a_two_step_plain: assert property (p_two_step_plain) else $error("two-step modified");

   property p_delay_1g;
      (link_mode == tstq_mode_1g) && (dly_sum < 32'h0001_0000)
         |=> rx_delay_ps == 16'($past(dly_sum));
   endproperty
   a_delay_1g: assert property (p_delay_1g) else $error("1G delay wrong");

endmodule

// file: inc/tstq_consts.svh
// Purpose: Offsets, field positions, reset values and codes of the stamp queue.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address, one word per register.
// Notes:   Definitions only.
`ifndef TSTQ_CONSTS_SVH
`define TSTQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TSTQ_AXI_AW          8
`define TSTQ_OFS_TX_STAMP    8'h00
`define TSTQ_OFS_ADVANCE     8'h04
`define TSTQ_OFS_STATUS      8'h08
`define TSTQ_OFS_REL_UPPER   8'h0c
`define TSTQ_OFS_REL_LOWER   8'h10
`define TSTQ_OFS_PORT_DIS    8'h14

// ----------------------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------------------
`define TSTQ_ST_VLD          0
`define TSTQ_ST_ID           1
`define TSTQ_ST_PORT         8
`define TSTQ_ST_OAM          16
`define TSTQ_ST_OVFL         17
`define TSTQ_PORT_DIS_RST    32'h0000_0000

// ----------------------------------------------------------------------------
// Codes and delay figures
// ----------------------------------------------------------------------------
`define TSTQ_OP_ONE_STEP     3'h2
`define TSTQ_OP_TWO_STEP     3'h3
`define TSTQ_OP_ORIGIN       3'h5
`define TSTQ_ID_NONE         6'h3f
`define TSTQ_ID_FIRST_ANA    6'h04
`define TSTQ_RX_ADJ_1G_PS    32'h0000_0320
`define TSTQ_RX_ADJ_2G5_PS   32'h0000_0140
`define TSTQ_RX_ADJ_FX_PS    32'h0000_0320
`define TSTQ_RESP_OKAY       2'h0
`define TSTQ_RESP_SLVERR     2'h2

`endif

// file: inc/tstq_pkg.sv
// Purpose: Types shared by the stamp queue and its neighbours.
// Assumes: Port numbers fit in eight bits, stamps in 32 bits.
// Notes:   Constants live in tstq_consts.svh.
package tstq_pkg;

   // -------------------------------------------------------------------------
   // Line modes for receive delay correction
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      tstq_mode_other,
      tstq_mode_1g,
      tstq_mode_2g5,
      tstq_mode_100fx
   } tstq_link_mode_t;

   // -------------------------------------------------------------------------
   // Classifier request and answer
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [2:0]  rewrite_operation;
      logic        to_cpu;
      logic        to_ports;
      logic [5:0]  dscp;
      logic [31:0] arrival_stamp;
   } tstq_cls_req_t;

   typedef struct packed {
      logic        valid;
      logic [5:0]  stamp_identifier;
      logic        two_step;
      logic        one_step_correction;
      logic        origin_write;
      logic        frame_modify;
      logic [5:0]  hdr_dscp;
      logic        hdr_arrival_valid;
      logic [31:0] hdr_arrival_stamp;
   } tstq_cls_rsp_t;

   // -------------------------------------------------------------------------
   // Egress departure stamp and queue entry
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [2:0]  rewrite_operation;
      logic        to_cpu;
      logic [7:0]  entry_tx_port;
      logic [5:0]  stamp_identifier;
      logic [31:0] stamp;
   } tstq_egr_stamp_t;

   typedef struct packed {
      logic [5:0]  stamp_identifier;
      logic [7:0]  entry_tx_port;
      logic        maintenance_origin_flag;
      logic [31:0] stamp;
   } tstq_entry_t;

endpackage

// file: verification/tb_top.sv
// Purpose: Self-checking bench of the stamp queue.
// Assumes: Register offsets and codes from tstq_consts.svh.
// Notes:   The overflow fill runs last; it fills the queue to its limit, then drains it and clears the overflow flag.
`include "tstq_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tstq_pkg::*;
   logic                aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]          s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]         s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0]          s_axi_wstrb = 4'hf;
   logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
   tstq_cls_req_t       cls_req;
   tstq_cls_rsp_t       cls_rsp, r;
   tstq_egr_stamp_t     egr_stamp;
   tstq_link_mode_t     link_mode = tstq_mode_other;
   logic [5:0]          barrel_delay = 6'h03, fx_edge_position = 6'h01;
   logic [15:0]         base_rx_delay_ps = 16'h03e8, rx_delay_ps;
   int                  error_cnt = 0, cmp_count = 0, cyc = 0;
   tstq_top tstq_top_i (.*);
   tstq_far_model tstq_far_model_i (.*);
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n != "") chk(n, e, d);
   endtask
   task automatic t_cls();
      logic [2:0] op[3] = '{3'h2, 3'h5, 3'h3};
      logic [3:0] ke[3] = '{4'h5, 4'h3, 4'h8};
      foreach (op[i]) begin
         tstq_far_model_i.frame(op[i], 1'b0, r);
         chk("kind", ke[i], {r.two_step, r.one_step_correction, r.origin_write, r.frame_modify});
      end
      chk("id", 32'h4, r.stamp_identifier);
      tstq_far_model_i.frame(3'h3, 1'b1, r);
      chk("hdr", 32'h0b, {r.hdr_dscp, r.hdr_arrival_valid});
      chk("arr", 32'h1234, r.hdr_arrival_stamp);
      repeat (57) tstq_far_model_i.frame(3'h3, 1'b0, r);
      chk("id", 32'h3e, r.stamp_identifier);
      tstq_far_model_i.frame(3'h3, 1'b0, r);
      chk("id", 32'h3f, r.stamp_identifier);
      wr(`TSTQ_OFS_REL_UPPER, 32'hffff_ffff);
      tstq_far_model_i.frame(3'h3, 1'b0, r);
      chk("id", 32'h20, r.stamp_identifier);
      wr(`TSTQ_OFS_REL_LOWER, 32'hffff_ffff);
      $display("t_cls done");
   endtask
   task automatic t_queue();
      rchk("st", `TSTQ_OFS_STATUS, 32'h0);
      wr(`TSTQ_OFS_ADVANCE, 32'h0);
      chk("bresp", `TSTQ_RESP_OKAY, rs);
      rchk("", 8'h20, 32'h0);
      chk("rresp", `TSTQ_RESP_SLVERR, rs);
      wr(8'h20, 32'h0);
      chk("bresp", `TSTQ_RESP_SLVERR, rs);
      tstq_far_model_i.stamp(8'h02, 6'h04, 32'haaaa);
      tstq_far_model_i.stamp(8'h05, 6'h04, 32'hbbbb);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0209);
      rchk("ts", `TSTQ_OFS_TX_STAMP, 32'haaaa);
      wr(`TSTQ_OFS_ADVANCE, 32'h0);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0509);
      wr(`TSTQ_OFS_ADVANCE, 32'h0);
      wr(`TSTQ_OFS_REL_LOWER, 32'h10);
      tstq_far_model_i.frame(3'h3, 1'b0, r);
      chk("id", 32'h4, r.stamp_identifier);
      wr(`TSTQ_OFS_PORT_DIS, 32'h4);
      rchk("dis", `TSTQ_OFS_PORT_DIS, 32'h4);
      tstq_far_model_i.stamp(8'h02, 6'h04, 32'h1);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0);
      wr(`TSTQ_OFS_PORT_DIS, 32'h0);
      $display("t_queue done");
   endtask
   task automatic t_dly();
      tstq_link_mode_t md[3] = '{tstq_mode_1g, tstq_mode_2g5, tstq_mode_100fx};
      logic [15:0] de[3] = '{16'h0d48, 16'h07a8, 16'h00c8};
      foreach (md[i]) begin
         @(posedge aclk);
         link_mode <= md[i];
         repeat (3) @(posedge aclk);
         chk("delay", de[i], rx_delay_ps);
      end
      $display("t_dly done");
   endtask
   task automatic t_ovf();
      repeat (129) tstq_far_model_i.stamp(8'h01, 6'h04, 32'h7);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0002_0109);
      repeat (128) wr(`TSTQ_OFS_ADVANCE, 32'h0);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0002_0000);
      wr(`TSTQ_OFS_STATUS, 32'h0002_0000);
      rchk("st", `TSTQ_OFS_STATUS, 32'h0);
      $display("t_ovf done");
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_cls();
      t_queue();
      t_dly();
      t_ovf();
      summarize();
   end
endmodule

// file: verification/tstq_far_model.sv
// Purpose: Analyzer and egress stamper stand-in facing the stamp queue.
// Assumes: Calls are made from the bench's main process, one at a time.
// Notes:   Pulses last one cycle, so back-to-back calls leave a one-cycle gap.
module tstq_far_model (
   // Clock
   input  wire logic                    aclk,
   // Toward the queue
   output tstq_pkg::tstq_cls_req_t      cls_req,
   output tstq_pkg::tstq_egr_stamp_t    egr_stamp,
   input  wire tstq_pkg::tstq_cls_rsp_t cls_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import tstq_pkg::*;
   initial cls_req = '0;
   initial egr_stamp = '0;
   // The answer is registered, so it is read just after the edge that takes the request.
   task automatic frame(input logic [2:0] op, input logic cpu, output tstq_cls_rsp_t r);
      @(posedge aclk);
      cls_req <= '{1'b1, op, cpu, 1'b1, 6'h2a, 32'h0000_1234};
      @(posedge aclk);
      cls_req <= '0;
      #1 r = cls_rsp;
   endtask
   task automatic stamp(input logic [7:0] p, input logic [5:0] id, input logic [31:0] v);
      @(posedge aclk);
      egr_stamp <= '{1'b1, 3'h3, 1'b0, p, id, v};
      @(posedge aclk);
      egr_stamp <= '0;
   endtask
endmodule
